// File: rtl/cimo_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cimo_cfg.svh"
// Summary of operation
// - switch overcurrent drives interrupt pin unless its mask bit is set
// - watchdog expiry drives interrupt pin unless its mask bit is set
// - entering reverse hiccup drives interrupt pin unless masked
// - entering reverse light-load disable drives interrupt pin unless masked
// - converter ready rising edge drives interrupt pin unless masked
// - high-impedance entry rising edge drives interrupt pin unless masked
// - charge suspend entry rising edge drives interrupt pin unless masked
// - reverse battery temperature fault rising edge in reverse mode drives pin unless masked
// - bus fault drives interrupt pin unless status bit 7 mask set
// - bit 6 shows battery-side current limit, only in reverse mode
// - bit 5 shows output current limit, only in reverse mode
// - bits 4 and 3 show live battery low and overvoltage in reverse mode
// - bits 2:0 show reverse state code, zero when not active, 5-7 invalid
module cimo_top (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output var  logic [7:0] reg_rdata_out,
  // event sources
  input  wire logic       sw_overcurrent_in,
  input  wire logic       watchdog_expiry_in,
  input  wire logic       reverse_hiccup_in,
  input  wire logic       reverse_light_load_in,
  input  wire logic       converter_ready_in,
  input  wire logic       high_impedance_in,
  input  wire logic       charge_suspend_in,
  input  wire logic       reverse_battery_temp_in,
  input  wire logic       bus_fault_in,
  input  wire logic       event_clear_in,
  // reverse mode status
  input  wire logic       reverse_active_in,
  input  wire logic       battery_current_limit_in,
  input  wire logic       output_current_limit_in,
  input  wire logic       battery_low_in,
  input  wire logic       battery_overvoltage_in,
  input  wire logic [2:0] reverse_state_in,
  // interrupt pin and pending events
  output var  logic       interrupt_pin_low_out,
  output var  logic [8:0] pending_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]           mask2;
    logic                 bus_fault_mask;
    logic                 bat_cc;
    logic                 out_cc;
    logic                 vlow;
    logic                 vov;
    cimo_pkg::cimo_state_t code;
    logic [8:0]           pend;
    logic [7:0]           rdata;
    logic                 irq_n;
  } cimo_st_t;
  cimo_st_t st_r;
  cimo_st_t st_nxt;
  logic [8:0] lvl;
  logic [8:0] rise;
  logic [8:0] masks;
  logic [8:0] hit;
  logic       wr_en;
  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  // level sources are edge-qualified too, so a stuck level fires once
  assign lvl = {bus_fault_in, sw_overcurrent_in, watchdog_expiry_in, reverse_hiccup_in,
                reverse_light_load_in, converter_ready_in, high_impedance_in,
                charge_suspend_in, reverse_battery_temp_in & reverse_active_in};
  cimo_edge #(.W(9)) u_edge (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .lvl_in      (lvl),
    .rise_out    (rise)
  );
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit
  function automatic cimo_pkg::cimo_state_t code_of(input logic act, input logic [2:0] c);
    // invalid codes shown as idle
    if (!act || c > `CIMO_STATE_MAX) begin
      code_of = cimo_pkg::CIMO_REVERSE_IDLE_STATE;
    end else begin
      code_of = cimo_pkg::cimo_state_t'(c);
    end
  endfunction : code_of
  assign masks = {st_r.bus_fault_mask, st_r.mask2};
  assign hit   = rise & ~masks;
  assign wr_en = ce_in & reg_wr_in;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (ce_in) begin
      if (wr_en && addr_hit(reg_addr_in, `CIMO_OFS_MASK2)) begin
        st_nxt.mask2 = reg_wdata_in;
      end
      if (wr_en && addr_hit(reg_addr_in, `CIMO_OFS_MASK_STAT)) begin
        st_nxt.bus_fault_mask = reg_wdata_in[`CIMO_BIT_BUSF];
      end
      // masking a source also drops its pending event; set wins over clear
      st_nxt.pend = ((st_r.pend & ~masks) & {9{~event_clear_in}}) | hit;
      st_nxt.bat_cc = reverse_active_in & battery_current_limit_in;
      st_nxt.out_cc = reverse_active_in & output_current_limit_in;
      st_nxt.vlow   = reverse_active_in & battery_low_in;
      st_nxt.vov    = reverse_active_in & battery_overvoltage_in;
      st_nxt.code   = code_of(reverse_active_in, reverse_state_in);
      st_nxt.irq_n  = ~(|(st_r.pend & ~masks));
      if (reg_rd_in) begin
        if (addr_hit(reg_addr_in, `CIMO_OFS_MASK2)) begin
          st_nxt.rdata = st_r.mask2;
        end else if (addr_hit(reg_addr_in, `CIMO_OFS_MASK_STAT)) begin
          st_nxt.rdata = {st_r.bus_fault_mask, st_r.bat_cc, st_r.out_cc,
                          st_r.vlow, st_r.vov, st_r.code};
        end else begin
          st_nxt.rdata = 8'h00;
        end
      end
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r                <= '0;
      st_r.mask2          <= `CIMO_RST_MASK2;
      st_r.bus_fault_mask <= 1'b0;
      st_r.irq_n          <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign reg_rdata_out         = st_r.rdata;
  assign interrupt_pin_low_out = st_r.irq_n;
  assign pending_out           = st_r.pend;
endmodule : cimo_top
`default_nettype wire

// File: rtl/cimo_cfg.svh
`ifndef CIMO_CFG_SVH
`define CIMO_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CIMO_OFS_MASK2      8'h1f
`define CIMO_OFS_MASK_STAT  8'h20
// ----------------------------------------
// reset values
// ----------------------------------------
`define CIMO_RST_MASK2      8'h00
`define CIMO_RST_MASK_STAT  8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define CIMO_BIT_SW_OC      7
`define CIMO_BIT_WDOG       6
`define CIMO_BIT_HICCUP     5
`define CIMO_BIT_LLOAD      4
`define CIMO_BIT_ADC        3
`define CIMO_BIT_HIZ        2
`define CIMO_BIT_SUSP       1
`define CIMO_BIT_BTEMP      0
`define CIMO_BIT_BUSF       7
`define CIMO_BIT_BAT_CC     6
`define CIMO_BIT_OUT_CC     5
`define CIMO_BIT_VLOW       4
`define CIMO_BIT_VOV        3
`define CIMO_STATE_HI       2
`define CIMO_STATE_LO       0
`define CIMO_STATE_MAX      3'h4
`endif

// File: rtl/cimo_pkg.sv
`default_nettype none
package cimo_pkg;
  typedef enum logic [2:0] {
    CIMO_REVERSE_IDLE_STATE = 3'b000,
    CIMO_ST1                = 3'b001,
    CIMO_ST2                = 3'b010,
    CIMO_ST3                = 3'b011,
    CIMO_ST4                = 3'b100
  } cimo_state_t;
endpackage : cimo_pkg
`default_nettype wire

// File: rtl/cimo_edge.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// rising edge detector, one bit per lane
// ----------------------------------------
module cimo_edge #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  // levels in, rising edges out
  input  wire logic [W-1:0] lvl_in,
  output var  logic [W-1:0] rise_out
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] rise;
  } cimo_edge_st_t;
  cimo_edge_st_t st_r;
  cimo_edge_st_t st_nxt;
  // a zero-lane detector has nothing to register
  if (W < 1) begin : g_bad_width
    $error("edge detector needs at least one lane");
  end
  always_comb begin
    st_nxt = st_r;
    if (ce_in) begin
      st_nxt.prev = lvl_in;
      st_nxt.rise = lvl_in & ~st_r.prev;
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rise_out = st_r.rise;
endmodule : cimo_edge
`default_nettype wire

// File: verification/cimo_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cimo_monitor (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       sw_overcurrent_in,
  input wire logic       watchdog_expiry_in,
  input wire logic       reverse_hiccup_in,
  input wire logic       converter_ready_in,
  input wire logic       reverse_battery_temp_in,
  input wire logic       bus_fault_in,
  input wire logic       reverse_active_in,
  input wire logic       interrupt_pin_low_out,
  input wire logic [8:0] pending_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // a pending bit may only rise two edges after its source was high
  AST_SWOC: assert property ($rose(pending_out[7]) |-> $past(sw_overcurrent_in, 2))
    else $error("overcurrent pending without cause");
  AST_WDOG: assert property ($rose(pending_out[6]) |-> $past(watchdog_expiry_in, 2))
    else $error("watchdog pending without cause");
  AST_HICC: assert property ($rose(pending_out[5]) |-> $past(reverse_hiccup_in, 2))
    else $error("hiccup pending without cause");
  AST_ADC: assert property ($rose(pending_out[3]) |-> $past(converter_ready_in, 2))
    else $error("converter pending without cause");
  AST_BTMP: assert property ($rose(pending_out[0]) |->
    $past(reverse_battery_temp_in && reverse_active_in, 2))
    else $error("temperature pending without cause");
  AST_BUSF: assert property ($rose(pending_out[8]) |-> $past(bus_fault_in, 2))
    else $error("bus fault pending without cause");
  AST_PIN: assert property ($rose(|pending_out) |=> !interrupt_pin_low_out)
    else $error("pin not low after pending");
  AST_OFF: assert property (reg_rd_in && reg_addr_in == 8'h20 && !reverse_active_in
    && !$past(reverse_active_in) |=> reg_rdata_out[6:0] == 7'h00)
    else $error("status not zero outside reverse mode");
endmodule : cimo_monitor
`default_nettype wire

// File: verification/cimo_host.sv
`timescale 1ns/10ps
`default_nettype none
// counts pin assertions the way a host edge interrupt would
module cimo_host (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       pin_low_in,
  output logic      [7:0] irq_count_out
);
  logic prev_r;
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_count_out <= 8'h00;
      prev_r <= 1'b1;
    end else begin
      prev_r <= pin_low_in;
      if (prev_r && !pin_low_in) irq_count_out <= irq_count_out + 8'h01;
    end
  end
endmodule : cimo_host
`default_nettype wire

// File: verification/test_charger_irq_mask_reverse_state_code.sv
`timescale 1ns/10ps
`default_nettype none
module test_charger_irq_mask_reverse_state_code;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, clr = 0, act = 0, ce = 1, pin;
  logic [7:0] addr = 0, wdata = 0, rdata, cnt;
  logic [8:0] ev = 0, pend;
  logic [6:0] st = 0;
  int         num_errors = 0, n_checks = 0;
  always #5 clk = ~clk;
  cimo_top i_cimo_top (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sw_overcurrent_in(ev[7]), .watchdog_expiry_in(ev[6]), .reverse_hiccup_in(ev[5]),
    .reverse_light_load_in(ev[4]), .converter_ready_in(ev[3]), .high_impedance_in(ev[2]),
    .charge_suspend_in(ev[1]), .reverse_battery_temp_in(ev[0]), .bus_fault_in(ev[8]),
    .event_clear_in(clr), .reverse_active_in(act), .battery_current_limit_in(st[6]),
    .output_current_limit_in(st[5]), .battery_low_in(st[4]), .battery_overvoltage_in(st[3]),
    .reverse_state_in(st[2:0]), .interrupt_pin_low_out(pin), .pending_out(pend));
  cimo_host i_cimo_host (.core_clk_in(clk), .rst_in(rst), .pin_low_in(pin), .irq_count_out(cnt));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string s, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wr_reg
  // rdata is registered, so look one edge after the read
  task rd_chk(input string s, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    chk(s, {1'b0, e}, {1'b0, rdata});
  endtask : rd_chk
  task test_reset;
    rd_chk("mask2", 8'h1f, 8'h00);
    rd_chk("status", 8'h20, 8'h00);
    rd_chk("unmapped", 8'h21, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task test_events;
    ev[0] = 1;
    repeat (4) @(negedge clk);
    chk("temp idle", 9'h000, pend);
    ev[0] = 0;
    act = 1;
    for (int i = 0; i < 9; i++) begin
      ev[i] = 1;
      repeat (4) @(negedge clk);
      chk("pending", 9'h001 << i, pend);
      chk("pin low", 9'h000, {8'h00, pin});
      ev[i] = 0;
      clr = 1;
      @(negedge clk);
      clr = 0;
      repeat (3) @(negedge clk);
      chk("pin idle", 9'h001, {8'h00, pin});
    end
    $display("test_events done");
  endtask : test_events
  task test_masked;
    wr_reg(8'h1f, 8'hff);
    wr_reg(8'h20, 8'hff); // status bits 6:0 refuse writes, bit 7 mask takes the write
    rd_chk("mask2", 8'h1f, 8'hff);
    rd_chk("status", 8'h20, 8'h80);
    for (int i = 0; i < 9; i++) begin
      ev[i] = 1;
      repeat (4) @(negedge clk);
      chk("masked", 9'h001, {pend != 9'h000, pin});
      ev[i] = 0;
    end
    $display("test_masked done");
  endtask : test_masked
  // a write while the enable is low must not land
  task test_freeze;
    ce = 0;
    wr_reg(8'h1f, 8'h00);
    ce = 1;
    rd_chk("frozen mask2", 8'h1f, 8'hff);
    $display("test_freeze done");
  endtask : test_freeze
  task test_status;
    st = 7'h53;
    rd_chk("status", 8'h20, 8'hd3);
    st = 7'h2e;
    rd_chk("status bad code", 8'h20, 8'ha8);
    act = 0;
    rd_chk("status off", 8'h20, 8'h80);
    $display("test_status done");
  endtask : test_status
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    test_reset;
    test_events;
    test_masked;
    test_freeze;
    test_status;
    chk("host count", 9'h009, {1'b0, cnt});
    print_verdict;
  end
  initial begin
    #20000;
    num_errors++;
    print_verdict;
  end
endmodule : test_charger_irq_mask_reverse_state_code
bind cimo_top cimo_monitor i_cimo_monitor (.core_clk_in, .rst_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .sw_overcurrent_in, .watchdog_expiry_in, .reverse_hiccup_in,
  .converter_ready_in, .reverse_battery_temp_in, .bus_fault_in, .reverse_active_in,
  .interrupt_pin_low_out, .pending_out);
`default_nettype wire
